//--- rtl/dhp_defines.svh
// constants for the dma handshake port: address, strobe and timing figures
// assumes one 20 MHz clock and a synchronous active-high reset
`ifndef DHP_DEFINES_SVH
`define DHP_DEFINES_SVH

`define DHP_ADDR_W 24
`define DHP_DATA_W 32
`define DHP_SEL_W 4
`define DHP_WAIT_W 3
`define DHP_SEL_ALL_OFF 4'h0
`define DHP_ADDR_SEL_LSB 22
`define DHP_WAIT_ZERO 3'h0
// grant set-up and release figures in whole clocks
`define DHP_SETUP_CYC 3'h1
`define DHP_HOLD_CYC 3'h1

`endif

//--- rtl/dhp_pkg.sv
// types shared by the dma handshake port
// assumes dhp_defines.svh supplies the numeric constants
package dhp_pkg;
   typedef enum logic [1:0] {
      DHP_MODE_HANDSHAKE,
      DHP_MODE_EXT_HANDSHAKE,
      DHP_MODE_PACED_MASTER,
      DHP_MODE_OFF
   } dhp_mode_t;

   typedef enum logic [2:0] {
      DHP_IDLE,
      DHP_SETUP,
      DHP_STROBE,
      DHP_PROLONG,
      DHP_RELEASE,
      DHP_GAP
   } dhp_state_t;
endpackage

//--- rtl/dhp_counter.sv
// down counter used for wait-state and gap timing
// assumes load is never asserted together with an undefined value
module dhp_counter #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // control
   input wire logic load_i,
   input wire logic [WIDTH-1:0] value_i,
   // status
   output logic zero_o
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   wire logic at_zero = (count_reg == '0);

   assign count_next = load_i ? value_i : (at_zero ? count_reg : count_reg - 1'b1);
   assign zero_o = at_zero;

   always_ff @(posedge clk_i) begin
      if (srst_i) count_reg <= '0;
      else count_reg <= count_next;
   end
endmodule

//--- rtl/dhp_port.sv
// dma handshake port: answers the peripheral's request in one of three modes
// assumes all pins are synchronous to clk_i; pad tri-stating lies outside
`include "dhp_defines.svh"
module dhp_port #(
   parameter int ADDR_W = `DHP_ADDR_W,
   parameter int DATA_W = `DHP_DATA_W,
   parameter int WAIT_W = `DHP_WAIT_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // configuration from the processor core
   input wire dhp_pkg::dhp_mode_t mode_i,
   input wire logic [WAIT_W-1:0] wait_states_i,
   input wire logic hold_idle_extra_cycle_i,
   input wire logic target_sdram_i,
   input wire logic write_dir_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   // peripheral request
   input wire logic dma_request_n_i,
   input wire logic ack_i,
   // bus data input
   input wire logic [DATA_W-1:0] data_i,
   // pins toward the peripheral or memory
   output logic dma_grant_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic sync_write_select_n_o,
   output logic [`DHP_SEL_W-1:0] memory_select_n_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   // results to the core
   output logic [DATA_W-1:0] rdata_o,
   output logic done_o,
   output logic refused_o
);
   dhp_pkg::dhp_state_t state_reg, state_next;
   dhp_pkg::dhp_mode_t mode_reg;
   logic write_reg;
   logic grant_n_reg, rd_n_reg, wr_n_reg, swsel_n_reg, oe_n_reg;
   logic [`DHP_SEL_W-1:0] sel_n_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] data_reg, rdata_reg;
   logic done_reg, refused_reg;
   logic cnt_load;
   logic [WAIT_W-1:0] cnt_value;
   logic cnt_zero;

   // a sampled low request is taken at this edge, no earlier
   wire logic req_seen = ~dma_request_n_i;
   wire logic ext_sdram = (mode_i == dhp_pkg::DHP_MODE_EXT_HANDSHAKE) & target_sdram_i;
   wire logic mode_on = (mode_i != dhp_pkg::DHP_MODE_OFF);
   wire logic start = (state_reg == dhp_pkg::DHP_IDLE) & req_seen & mode_on & ~ext_sdram;
   wire logic refuse = (state_reg == dhp_pkg::DHP_IDLE) & req_seen & ext_sdram;
   wire logic uses_grant = (mode_reg != dhp_pkg::DHP_MODE_PACED_MASTER);
   wire logic uses_bus = (mode_reg != dhp_pkg::DHP_MODE_HANDSHAKE);
   // extended handshake and paced master also wait for the slave's acknowledge
   wire logic bus_ready = ~uses_bus | ack_i;
   wire logic strobe_end = (state_reg == dhp_pkg::DHP_STROBE) & cnt_zero & bus_ready;
   wire logic [1:0] sel_idx = addr_reg[`DHP_ADDR_SEL_LSB +: 2];
   wire logic [`DHP_SEL_W-1:0] sel_onehot = `DHP_SEL_W'(1) << sel_idx;
   wire logic [WAIT_W-1:0] gap_len = WAIT_W'(`DHP_HOLD_CYC)
      + WAIT_W'(hold_idle_extra_cycle_i);

   // counter loads: wait states on strobe entry, gap on release
   assign cnt_load = (state_reg == dhp_pkg::DHP_SETUP)
      | (state_reg == dhp_pkg::DHP_RELEASE);
   assign cnt_value = (state_reg == dhp_pkg::DHP_SETUP) ? wait_states_i : gap_len;

   dhp_counter #(.WIDTH(WAIT_W)) u_counter (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .load_i(cnt_load),
      .value_i(cnt_value),
      .zero_o(cnt_zero)
   );

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         dhp_pkg::DHP_IDLE: if (start) state_next = dhp_pkg::DHP_SETUP;
         dhp_pkg::DHP_SETUP: state_next = dhp_pkg::DHP_STROBE;
         dhp_pkg::DHP_STROBE: begin
            // a request still low holds off completion
            if (strobe_end) begin
               state_next = req_seen ? dhp_pkg::DHP_PROLONG : dhp_pkg::DHP_RELEASE;
            end
         end
         dhp_pkg::DHP_PROLONG: if (!req_seen) state_next = dhp_pkg::DHP_RELEASE;
         dhp_pkg::DHP_RELEASE: state_next = dhp_pkg::DHP_GAP;
         dhp_pkg::DHP_GAP: if (cnt_zero) state_next = dhp_pkg::DHP_IDLE;
         default: state_next = dhp_pkg::DHP_IDLE;
      endcase
   end

   wire logic active = (state_reg == dhp_pkg::DHP_STROBE)
      | (state_reg == dhp_pkg::DHP_PROLONG);
   wire logic in_xfer = (state_reg == dhp_pkg::DHP_SETUP) | active;
   wire logic finish = (state_reg == dhp_pkg::DHP_RELEASE);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= dhp_pkg::DHP_IDLE;
         mode_reg <= dhp_pkg::DHP_MODE_OFF;
         write_reg <= 1'b0;
         addr_reg <= '0;
         data_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (start) begin
            mode_reg <= mode_i;
            write_reg <= write_dir_i;
            addr_reg <= addr_i;
            data_reg <= wdata_i;
         end
      end
   end

   // pin registers: strobes low only while the word is in flight
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         grant_n_reg <= 1'b1;
         rd_n_reg <= 1'b1;
         wr_n_reg <= 1'b1;
         swsel_n_reg <= 1'b1;
         sel_n_reg <= ~`DHP_SEL_ALL_OFF;
         oe_n_reg <= 1'b1;
      end else begin
         grant_n_reg <= ~(state_next_active() & uses_grant_next());
         rd_n_reg <= ~(state_next_active() & uses_bus_next() & ~write_next());
         wr_n_reg <= ~(state_next_active() & uses_bus_next() & write_next());
         swsel_n_reg <= ~(state_next_in() & ext_next() & write_next());
         sel_n_reg <= (state_next_in() & uses_bus_next()) ? ~sel_onehot_next()
            : ~`DHP_SEL_ALL_OFF;
         oe_n_reg <= ~(state_next_in() & write_next());
      end
   end

   // next-cycle views so the pins change on the same edge as the state
   function automatic logic state_next_active();
      return (state_next == dhp_pkg::DHP_STROBE) | (state_next == dhp_pkg::DHP_PROLONG);
   endfunction
   function automatic logic state_next_in();
      return state_next_active() | (state_next == dhp_pkg::DHP_SETUP);
   endfunction
   function automatic logic write_next();
      return start ? write_dir_i : write_reg;
   endfunction
   function automatic logic uses_grant_next();
      return start ? (mode_i != dhp_pkg::DHP_MODE_PACED_MASTER) : uses_grant;
   endfunction
   function automatic logic uses_bus_next();
      return start ? (mode_i != dhp_pkg::DHP_MODE_HANDSHAKE) : uses_bus;
   endfunction
   function automatic logic ext_next();
      return start ? (mode_i == dhp_pkg::DHP_MODE_EXT_HANDSHAKE)
         : (mode_reg == dhp_pkg::DHP_MODE_EXT_HANDSHAKE);
   endfunction
   function automatic logic [`DHP_SEL_W-1:0] sel_onehot_next();
      return start ? (`DHP_SEL_W'(1) << addr_i[`DHP_ADDR_SEL_LSB +: 2]) : sel_onehot;
   endfunction

   // read data is caught at the end of the release cycle, one clock after the strobe ends, after any prolonging
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_reg <= '0;
         done_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         if (finish & ~write_reg) rdata_reg <= data_i;
         done_reg <= finish;
         refused_reg <= refuse;
      end
   end

   assign dma_grant_n_o = grant_n_reg;
   assign rd_n_o = rd_n_reg;
   assign wr_n_o = wr_n_reg;
   assign sync_write_select_n_o = swsel_n_reg;
   assign memory_select_n_o = sel_n_reg;
   assign addr_o = addr_reg;
   assign data_o = data_reg;
   assign data_oe_n_o = oe_n_reg;
   assign rdata_o = rdata_reg;
   assign done_o = done_reg;
   assign refused_o = refused_reg;

   wire logic unused_ok = in_xfer | active;
endmodule

//--- verification/dhp_port_assertions.sv
// concurrent checks on the dma handshake port pins
// assumes mode_i stays steady while a word is in flight
module dhp_port_assertions (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // configuration and request
   input wire dhp_pkg::dhp_mode_t mode_i,
   input wire logic [2:0] wait_states_i,
   input wire logic hold_idle_extra_cycle_i,
   input wire logic target_sdram_i,
   input wire logic dma_request_n_i,
   // observed pins
   input wire logic dma_grant_n_o,
   input wire logic rd_n_o,
   input wire logic wr_n_o,
   input wire logic refused_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic [7:0] low_cnt;
   // counts grant-low cycles so the wait figure can be checked at release
   always_ff @(posedge clk_i) begin
      if (srst_i || dma_grant_n_o) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   AST_START: assert property ($fell(dma_grant_n_o) |-> !$past(dma_request_n_i, 2))
      else $error("grant without request");
   AST_HS_BUS: assert property ((mode_i == dhp_pkg::DHP_MODE_HANDSHAKE) |-> rd_n_o && wr_n_o)
      else $error("bus strobe in handshake mode");
   AST_SDRAM: assert property (refused_o |->
      $past(mode_i == dhp_pkg::DHP_MODE_EXT_HANDSHAKE && target_sdram_i) && dma_grant_n_o)
      else $error("bad refusal");
   AST_PACED: assert property ((mode_i == dhp_pkg::DHP_MODE_PACED_MASTER) |-> dma_grant_n_o)
      else $error("grant in paced mode");
   AST_PROLONG: assert property (!dma_grant_n_o && !dma_request_n_i |=> !dma_grant_n_o)
      else $error("grant ended under held request");
   AST_WAIT: assert property ($rose(dma_grant_n_o) |-> low_cnt > {5'h00, wait_states_i})
      else $error("grant low too short");
   AST_GAP: assert property ($rose(dma_grant_n_o) |-> dma_grant_n_o [*4])
      else $error("grant high gap too short");
   AST_GAP_EXTRA: assert property ($rose(dma_grant_n_o) && hold_idle_extra_cycle_i |->
      dma_grant_n_o [*5]) else $error("extra gap cycle missing");
   cover property (refused_o);
   cover property ($rose(dma_grant_n_o) && hold_idle_extra_cycle_i);
   cover property (!rd_n_o && !dma_request_n_i);
endmodule

bind dhp_port dhp_port_assertions chk_u (.clk_i, .srst_i, .mode_i, .wait_states_i,
   .hold_idle_extra_cycle_i, .target_sdram_i, .dma_request_n_i, .dma_grant_n_o, .rd_n_o,
   .wr_n_o, .refused_o);

//--- verification/dhp_periph_model.sv
// peripheral that requests single words, prolongs and acknowledges them
// assumes the bench holds go_i until done and then drops it
module dhp_periph_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // bench control
   input wire logic go_i,
   input wire logic [3:0] prolong_i,
   input wire logic [3:0] ack_wait_i,
   input wire logic [31:0] word_i,
   // port pins
   input wire logic dma_grant_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   output logic dma_request_n_o,
   output logic ack_o,
   output logic [31:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic stb;
   logic fin;
   logic [3:0] cnt;
   assign stb = !(dma_grant_n_i && rd_n_i && wr_n_i);
   assign dma_request_n_o = !(go_i && !fin);
   assign ack_o = stb && (cnt >= ack_wait_i);
   // bus shows the inverse until the word is ready, so early capture fails
   assign data_o = fin ? word_i : ~word_i;
   always_ff @(posedge clk_i) begin
      if (srst_i || !go_i) begin
         cnt <= 4'h0;
         fin <= 1'b0;
      end else if (stb) begin
         cnt <= cnt + 4'h1;
         fin <= fin || (cnt >= prolong_i);
      end
   end
endmodule

//--- verification/testbench.sv
// self-checking bench for the dma handshake port and its peripheral model
// assumes the checker binds itself; inputs change on falling edges
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0, srst_i = 1'b1, go = 1'b0, write_dir_i = 1'b0;
   logic hold_idle_extra_cycle_i = 1'b0, target_sdram_i = 1'b0;
   dhp_pkg::dhp_mode_t mode_i = dhp_pkg::DHP_MODE_OFF;
   logic [2:0] wait_states_i = 3'h0;
   logic [3:0] prl = 4'h0, ackw = 4'h0, memory_select_n_o;
   logic [23:0] addr_i = 24'h80_0000, addr_o;
   logic [31:0] wdata_i = 32'h0000_0000, data_i, data_o, rdata_o;
   logic dma_request_n_i, ack_i, dma_grant_n_o, rd_n_o, wr_n_o, sync_write_select_n_o;
   logic data_oe_n_o, done_o, refused_o;
   int fail_count = 0, total_checks = 0, cyc = 0;
   dhp_port dut_u (.clk_i, .srst_i, .mode_i, .wait_states_i, .hold_idle_extra_cycle_i,
      .target_sdram_i, .write_dir_i, .addr_i, .wdata_i, .dma_request_n_i, .ack_i, .data_i,
      .dma_grant_n_o, .rd_n_o, .wr_n_o, .sync_write_select_n_o, .memory_select_n_o, .addr_o,
      .data_o, .data_oe_n_o, .rdata_o, .done_o, .refused_o);
   dhp_periph_model peer_u (.clk_i, .srst_i, .go_i(go), .prolong_i(prl), .ack_wait_i(ackw),
      .word_i(wdata_i), .dma_grant_n_i(dma_grant_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
      .dma_request_n_o(dma_request_n_i), .ack_o(ack_i), .data_o(data_i));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // the whole run needs under two hundred cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         end_of_test();
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xfer(input dhp_pkg::dhp_mode_t m, input logic w, input logic [2:0] ws,
         input logic h, input logic [3:0] p, input logic [3:0] a, input logic [31:0] d);
      int n;
      int lo;
      logic [5:0] pins;
      logic [5:0] pins_e;
      @(negedge clk_i);
      mode_i = m;
      {write_dir_i, wait_states_i, hold_idle_extra_cycle_i} = {w, ws, h};
      {prl, ackw, wdata_i, go} = {p, a, d, 1'b1};
      n = 0;
      lo = 0;
      pins = 6'h00;
      // select lines from address bits 23:22 = 2, so line 2 low; none in handshake mode
      pins_e[5:2] = (m == dhp_pkg::DHP_MODE_HANDSHAKE) ? 4'hF : 4'hB;
      pins_e[1] = ~((m == dhp_pkg::DHP_MODE_EXT_HANDSHAKE) && w);
      pins_e[0] = ~w;
      while (done_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
         if ({dma_grant_n_o, rd_n_o, wr_n_o} !== 3'h7) begin
            lo++;
            pins = {memory_select_n_o, sync_write_select_n_o, data_oe_n_o};
         end
      end
      go = 1'b0;
      chk("done", 32'h1, {31'h0, done_o});
      chk("word", d, w ? data_o : rdata_o);
      chk("strobe cycles", 32'h1, {31'h0, lo > ws && lo > p});
      chk("select pins", {26'h0, pins_e}, {26'h0, pins});
      chk("address", {8'h00, addr_i}, {8'h00, addr_o});
   endtask
   task sc_modes;
      xfer(dhp_pkg::DHP_MODE_HANDSHAKE, 1'b0, 3'h2, 1'b0, 4'h0, 4'h0, 32'h1234_5678);
      xfer(dhp_pkg::DHP_MODE_EXT_HANDSHAKE, 1'b0, 3'h0, 1'b1, 4'h0, 4'h3, 32'hA5A5_0F0F);
      xfer(dhp_pkg::DHP_MODE_PACED_MASTER, 1'b0, 3'h1, 1'b0, 4'h0, 4'h2, 32'h0F0F_A5A5);
   endtask
   task sc_prolong;
      xfer(dhp_pkg::DHP_MODE_HANDSHAKE, 1'b1, 3'h0, 1'b0, 4'h6, 4'h0, 32'hDEAD_0001);
      xfer(dhp_pkg::DHP_MODE_HANDSHAKE, 1'b0, 3'h7, 1'b1, 4'h9, 4'h0, 32'h0000_BEEF);
      xfer(dhp_pkg::DHP_MODE_EXT_HANDSHAKE, 1'b1, 3'h3, 1'b0, 4'h5, 4'h1, 32'h7777_0000);
   endtask
   task sc_refuse;
      int n;
      @(negedge clk_i);
      mode_i = dhp_pkg::DHP_MODE_EXT_HANDSHAKE;
      target_sdram_i = 1'b1;
      go = 1'b1;
      n = 0;
      while (refused_o !== 1'b1 && n < 5) begin
         @(negedge clk_i);
         n++;
      end
      chk("refused", 32'h1, {31'h0, refused_o});
      go = 1'b0;
      xfer(dhp_pkg::DHP_MODE_PACED_MASTER, 1'b1, 3'h0, 1'b0, 4'h0, 4'h1, 32'h5A5A_C3C3);
      target_sdram_i = 1'b0;
   endtask
   task sc_off;
      int seen;
      @(negedge clk_i);
      mode_i = dhp_pkg::DHP_MODE_OFF;
      go = 1'b1;
      seen = 0;
      repeat (10) begin
         @(negedge clk_i);
         if (done_o !== 1'b0 || dma_grant_n_o !== 1'b1) seen++;
      end
      go = 1'b0;
      chk("off activity", 32'h0, seen);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      sc_modes();
      sc_prolong();
      sc_refuse();
      sc_off();
      end_of_test();
   end
endmodule
